// [design/pbc_pkg.sv]
package pbc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] PBC_HDR_OFS  = 12'h20c;
  localparam logic [11:0] PBC_SEL_OFS  = 12'h210;
  localparam logic [11:0] PBC_DATA_OFS = 12'h214;
  localparam logic [11:0] PBC_FLAG_OFS = 12'h218;

  // ****************************************
  // Header constants
  // ****************************************
  localparam logic [15:0] PBC_CAP_ID   = 16'h0004;
  localparam logic [3:0]  PBC_CAP_VER  = 4'h1;
  localparam logic [11:0] PBC_NEXT_UP  = 12'h230;
  localparam logic [11:0] PBC_NEXT_DN  = 12'h220;

  // ****************************************
  // Index values and field positions
  // ****************************************
  localparam logic [7:0]  PBC_SEL_RESET = 8'h00;
  localparam logic [7:0]  PBC_SEL_D0MAX = 8'h00;
  localparam logic [7:0]  PBC_SEL_D0SUS = 8'h01;
  localparam int          PBC_BASE_LSB  = 0;
  localparam int          PBC_SCALE_LSB = 8;
  localparam int          PBC_SUB_LSB   = 10;
  localparam int          PBC_STATE_LSB = 13;
  localparam int          PBC_TYPE_LSB  = 15;
  localparam int          PBC_RAIL_LSB  = 18;
  localparam int          PBC_DESC_W    = 21;
  localparam int          PBC_FLAG_BIT  = 0;

  // ****************************************
  // Reset values and fixed entry types
  // ****************************************
  localparam logic [7:0]  PBC_BASE_RESET  = 8'h04;
  localparam logic [1:0]  PBC_SCALE_RESET = 2'h0;
  localparam logic [2:0]  PBC_SUB_RESET   = 3'h0;
  localparam logic [1:0]  PBC_STATE_RESET = 2'h0;
  localparam logic [2:0]  PBC_TYPE_MAX    = 3'h7;
  localparam logic [2:0]  PBC_TYPE_SUS    = 3'h3;
  localparam logic [2:0]  PBC_RAIL_RESET  = 3'h2;
  localparam logic        PBC_FLAG_RESET  = 1'h0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [2:0] rail;
    logic [2:0] condType;
    logic [1:0] pmState;
    logic [2:0] subState;
    logic [1:0] scale;
    logic [7:0] basePower;
  } pbc_desc_type;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [3:0]  byteEn;
    logic [11:0] addr;
    logic [31:0] wrData;
  } pbc_cfg_req_type;

  typedef struct packed {
    logic       load;
    logic       entry;
    logic [7:0] basePower;
    logic [1:0] scale;
    logic [1:0] pmState;
    logic       flagLoad;
    logic       flag;
  } pbc_sideband_type;

endpackage : pbc_pkg

// [design/pbc_entry_store.sv]
`timescale 1ns/1ns
module pbc_entry_store #(
  parameter int ENTRIES = 2
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  pbc_pkg::pbc_sideband_type  sideband,
  input  wire logic [7:0]            selectIndex,
  output pbc_pkg::pbc_desc_type      entryDesc
);

  // ****************************************
  // Overwritable fields per entry
  // ****************************************
  logic [7:0] base_q  [ENTRIES];
  logic [1:0] scale_q [ENTRIES];
  logic [1:0] state_q [ENTRIES];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        base_q[i]  <= pbc_pkg::PBC_BASE_RESET;
        scale_q[i] <= pbc_pkg::PBC_SCALE_RESET;
        state_q[i] <= pbc_pkg::PBC_STATE_RESET;
      end
    end else if (sideband.load) begin
      base_q[sideband.entry]  <= sideband.basePower;
      scale_q[sideband.entry] <= sideband.scale;
      state_q[sideband.entry] <= sideband.pmState;
    end
  end

  // ****************************************
  // Entry mux
  // ****************************************
  // Combinational so the data word tracks a new index with no extra cycle
  always_comb begin
    entryDesc = '0;
    if (selectIndex < 8'(ENTRIES)) begin
      entryDesc.basePower = base_q[selectIndex[0]];
      entryDesc.scale     = scale_q[selectIndex[0]];
      entryDesc.subState  = pbc_pkg::PBC_SUB_RESET;
      entryDesc.pmState   = state_q[selectIndex[0]];
      entryDesc.condType  = (selectIndex == pbc_pkg::PBC_SEL_D0MAX) ?
                            pbc_pkg::PBC_TYPE_MAX : pbc_pkg::PBC_TYPE_SUS;
      entryDesc.rail      = pbc_pkg::PBC_RAIL_RESET;
    end
  end

endmodule : pbc_entry_store

// [design/pbc_regs.sv]
`timescale 1ns/1ns
module pbc_regs (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  upstreamPin,
  input  pbc_pkg::pbc_cfg_req_type   cfgReq,
  input  pbc_pkg::pbc_sideband_type  sideband,
  output logic [31:0]                cfgRdData,
  output logic                       cfgRdValid
);

  // ****************************************
  // Strap synchroniser
  // ****************************************
  logic upSync1_q;
  logic upSync2_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upSync1_q <= 1'b0;
      upSync2_q <= 1'b0;
    end else begin
      upSync1_q <= upstreamPin;
      upSync2_q <= upSync1_q;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  // One shared compare keeps the write strobe, the read checks and the assertions in step
  function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction : addrHit

  // ****************************************
  // Selection index and flag
  // ****************************************
  logic [7:0]  select_q;
  logic        sysFlag_q;
  logic        selWrite;
  pbc_pkg::pbc_desc_type entryDesc;

  // Only byte lane 0 carries the index, upper lanes are reserved
  assign selWrite = cfgReq.wrEn && cfgReq.byteEn[0]
                    && addrHit(cfgReq.addr, pbc_pkg::PBC_SEL_OFS);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      select_q <= pbc_pkg::PBC_SEL_RESET;
    end else if (selWrite) begin
      select_q <= cfgReq.wrData[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sysFlag_q <= pbc_pkg::PBC_FLAG_RESET;
    end else if (sideband.flagLoad) begin
      sysFlag_q <= sideband.flag;
    end
  end

  pbc_entry_store #(
    .ENTRIES (2)
  ) u_store (
    .clock       (clock),
    .rst         (rst),
    .sideband    (sideband),
    .selectIndex (select_q),
    .entryDesc   (entryDesc)
  );

  // ****************************************
  // Read path
  // ****************************************
  logic [31:0] rdMux;
  logic [11:0] nextPtr;

  // Follows the strap live, so a late strap change shows two edges later
  assign nextPtr = upSync2_q ? pbc_pkg::PBC_NEXT_UP : pbc_pkg::PBC_NEXT_DN;

  // Unmapped offsets fall to zero so probing software sees nothing there
  always_comb begin
    case (cfgReq.addr)
      pbc_pkg::PBC_HDR_OFS:  rdMux = {nextPtr, pbc_pkg::PBC_CAP_VER, pbc_pkg::PBC_CAP_ID};
      pbc_pkg::PBC_SEL_OFS:  rdMux = {24'h000000, select_q};
      pbc_pkg::PBC_DATA_OFS: rdMux = {11'h000, entryDesc};
      pbc_pkg::PBC_FLAG_OFS: rdMux = {31'h00000000, sysFlag_q};
      default:               rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfgRdData  <= 32'h00000000;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgReq.rdEn;
      if (cfgReq.rdEn) begin
        cfgRdData <= rdMux;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic rdData, rdHdr, rdFlag, rdSel;
  assign rdData = cfgReq.rdEn && addrHit(cfgReq.addr, pbc_pkg::PBC_DATA_OFS);
  assign rdHdr  = cfgReq.rdEn && addrHit(cfgReq.addr, pbc_pkg::PBC_HDR_OFS);
  assign rdFlag = cfgReq.rdEn && addrHit(cfgReq.addr, pbc_pkg::PBC_FLAG_OFS);
  assign rdSel  = cfgReq.rdEn && addrHit(cfgReq.addr, pbc_pkg::PBC_SEL_OFS);

  // No request is taken while reset is high, so the first edge after it shows the defaults
  a_reset_values: assert property (
    $fell(rst)
    |-> select_q == pbc_pkg::PBC_SEL_RESET && sysFlag_q == pbc_pkg::PBC_FLAG_RESET
        && !cfgRdValid && cfgRdData == 32'h00000000)
    else $error("Index, flag or read port not at reset value after reset");

  a_sel_write_then_read: assert property (
    selWrite ##1 rdSel |=> cfgRdData == {24'h000000, $past(cfgReq.wrData[7:0], 2)})
    else $error("Selection index did not take the written value");

  a_sel_hold_steady: assert property (
    !selWrite |=> $stable(select_q))
    else $error("Selection index changed without a write");

  a_sel_reserved: assert property (
    rdSel |=> cfgRdData[31:8] == 24'h000000)
    else $error("Reserved bits of the selection index not zero");

  a_unsupported_zero: assert property (
    rdData && (select_q > pbc_pkg::PBC_SEL_D0SUS) |=> cfgRdData == 32'h00000000)
    else $error("Unsupported entry did not read zero");

  // An index beyond the two entries must blank the data on the very next read
  a_data_follows_sel: assert property (
    selWrite && (cfgReq.wrData[7:0] > pbc_pkg::PBC_SEL_D0SUS) ##1 rdData
    |=> cfgRdData == 32'h00000000)
    else $error("Data did not follow an unsupported index at once");

  a_max_entry_type: assert property (
    rdData && (select_q == pbc_pkg::PBC_SEL_D0MAX)
    |=> cfgRdData[pbc_pkg::PBC_TYPE_LSB +: 3] == pbc_pkg::PBC_TYPE_MAX)
    else $error("D0 maximum entry has wrong type");

  a_sus_entry_type: assert property (
    rdData && (select_q == pbc_pkg::PBC_SEL_D0SUS)
    |=> cfgRdData[pbc_pkg::PBC_TYPE_LSB +: 3] == pbc_pkg::PBC_TYPE_SUS)
    else $error("D0 sustained entry has wrong type");

  a_rail_and_substate: assert property (
    rdData && (select_q <= pbc_pkg::PBC_SEL_D0SUS)
    |=> cfgRdData[pbc_pkg::PBC_RAIL_LSB +: 3] == pbc_pkg::PBC_RAIL_RESET
        && cfgRdData[pbc_pkg::PBC_SUB_LSB +: 3] == pbc_pkg::PBC_SUB_RESET
        && cfgRdData[31:pbc_pkg::PBC_DESC_W] == 11'h000)
    else $error("Rail, substate or reserved bits wrong");

  a_header_fixed: assert property (
    rdHdr |=> cfgRdData[19:0] == {pbc_pkg::PBC_CAP_VER, pbc_pkg::PBC_CAP_ID})
    else $error("Header identifier or version wrong");

  a_next_pointer: assert property (
    rdHdr && $stable(upSync2_q)
    |=> cfgRdData[31:20] == ($past(upSync2_q) ? pbc_pkg::PBC_NEXT_UP : pbc_pkg::PBC_NEXT_DN))
    else $error("Next capability pointer wrong for port role");

  a_unmapped_zero: assert property (
    cfgReq.rdEn && !rdData && !rdHdr && !rdFlag && !rdSel |=> cfgRdData == 32'h00000000)
    else $error("Unmapped read did not return zero");

  a_flag_reserved: assert property (
    rdFlag |=> cfgRdData[31:1] == 31'h00000000)
    else $error("Reserved bits of the flag register not zero");

  // ****************************************
  // Sideband assertions
  // ****************************************
  a_flag_sideband: assert property (
    sideband.flagLoad ##1 rdFlag |=> cfgRdData == {31'h00000000, $past(sideband.flag, 2)})
    else $error("Sideband flag load not visible");

  a_flag_hold: assert property (
    !sideband.flagLoad |=> $stable(sysFlag_q))
    else $error("System flag changed without a sideband load");

  a_base_sideband: assert property (
    sideband.load && !selWrite && (sideband.entry == select_q[0])
    && (select_q <= pbc_pkg::PBC_SEL_D0SUS) ##1 (rdData && !sideband.load)
    |=> cfgRdData[7:0] == $past(sideband.basePower, 2))
    else $error("Sideband base power not visible");

  a_scale_state_sideband: assert property (
    sideband.load && !selWrite && (sideband.entry == select_q[0])
    && (select_q <= pbc_pkg::PBC_SEL_D0SUS) ##1 (rdData && !sideband.load)
    |=> cfgRdData[pbc_pkg::PBC_SCALE_LSB +: 2] == $past(sideband.scale, 2)
        && cfgRdData[pbc_pkg::PBC_STATE_LSB +: 2] == $past(sideband.pmState, 2))
    else $error("Sideband scale or state not visible");

  // ****************************************
  // Read port timing
  // ****************************************
  a_read_latency: assert property (
    cfgRdValid == $past(cfgReq.rdEn))
    else $error("Read answer not one cycle after request");

  // Software may look at the answer late, so it must not drift between reads
  a_data_hold: assert property (
    !cfgReq.rdEn |=> $stable(cfgRdData))
    else $error("Read data changed without a read");

  // ****************************************
  // Covers
  // ****************************************
  c_read_max: cover property (rdData && select_q == pbc_pkg::PBC_SEL_D0MAX);
  c_read_sus: cover property (rdData && select_q == pbc_pkg::PBC_SEL_D0SUS);
  c_read_unsup: cover property (rdData && select_q > pbc_pkg::PBC_SEL_D0SUS);
  c_sb_load: cover property (sideband.load ##1 rdData);
  c_flag_load: cover property (sideband.flagLoad ##1 rdFlag);

endmodule : pbc_regs

// [verification/pbc_regs_tb.sv]
`timescale 1ns/1ns
module pbc_regs_tb;
  logic                      clock;
  logic                      rst;
  logic                      upstreamPin;
  pbc_pkg::pbc_cfg_req_type  cfgReq;
  pbc_pkg::pbc_sideband_type sideband;
  logic [31:0]               cfgRdData;
  logic                      cfgRdValid;
  int                        nMismatch;
  int                        checksDone;
  logic [31:0]               seed;
  logic [7:0]                mBase [2];
  logic [1:0]                mScale [2];
  logic [1:0]                mState [2];
  logic                      mFlag;
  logic [7:0]                mSel;
  logic [31:0]               r;
  logic [31:0]               eNext;

  pbc_regs pbc_regs_inst (
    .clock       (clock),
    .rst         (rst),
    .upstreamPin (upstreamPin),
    .cfgReq      (cfgReq),
    .sideband    (sideband),
    .cfgRdData   (cfgRdData),
    .cfgRdValid  (cfgRdValid)
  );

  always #25 clock = ~clock;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Types differ per entry; rail and substate are fixed
  function automatic logic [31:0] expData(input logic [7:0] idx);
    if (idx > 8'h01) begin
      return 32'h0;
    end
    return {11'h0, 3'h2, (idx[0] ? 3'h3 : 3'h7), mState[idx[0]], 3'h0,
            mScale[idx[0]], mBase[idx[0]]};
  endfunction : expData

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    cfgReq <= '{wrEn: 1'b1, rdEn: 1'b0, byteEn: be, addr: a, wrData: d};
    @(posedge clock);
    cfgReq.wrEn <= 1'b0;
  endtask : wr

  // Valid stands one cycle only, so it is looked at right after the answer edge
  task automatic rdNow(input logic [11:0] a, input logic [31:0] e);
    cfgReq <= '{wrEn: 1'b0, rdEn: 1'b1, byteEn: 4'h0, addr: a, wrData: 32'h0};
    @(posedge clock);
    cfgReq.rdEn <= 1'b0;
    #1;
    chk("rdValid", 32'h1, {31'h0, cfgRdValid});
    chk($sformatf("rdData %h", a), e, cfgRdData);
  endtask : rdNow

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    rdNow(a, e);
  endtask : rd

  // Write, then read on the very next edge, the tightest spacing the port allows
  task automatic wrRd(input logic [11:0] wa, input logic [31:0] wd, input logic [3:0] be,
                      input logic [11:0] ra, input logic [31:0] e);
    @(posedge clock);
    cfgReq <= '{wrEn: 1'b1, rdEn: 1'b0, byteEn: be, addr: wa, wrData: wd};
    @(posedge clock);
    rdNow(ra, e);
  endtask : wrRd

  task automatic modelReset();
    mBase  = '{8'h04, 8'h04};
    mScale = '{2'h0, 2'h0};
    mState = '{2'h0, 2'h0};
    mFlag  = 1'b0;
    mSel   = 8'h00;
  endtask : modelReset

  task automatic close_out();
    if (nMismatch == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    upstreamPin = 1'b0;
    cfgReq = '0;
    sideband = '0;
    nMismatch = 0;
    checksDone = 0;
    seed = 32'h9c4633be;
    modelReset();
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(12'h210, 32'h0);
    rd(12'h214, 32'h000b8004);
    rd(12'h218, 32'h0);
    rd(12'h20c, {12'h220, 4'h1, 16'h0004});
    wr(12'h210, 32'hffffff01, 4'hf);
    mSel = 8'h01;
    rd(12'h210, 32'h01);
    rd(12'h214, expData(8'h01));
    wr(12'h210, 32'h00000002, 4'he);
    rd(12'h210, 32'h01);
    @(posedge clock);
    upstreamPin <= 1'b1;
    repeat (3) @(posedge clock);
    rd(12'h20c, {12'h230, 4'h1, 16'h0004});
    // Random mix of sideband loads, index moves and ignored writes
    for (int i = 0; i < 60; i++) begin
      r = xs();
      @(posedge clock);
      sideband <= '{load: r[0], entry: r[1], basePower: r[15:8], scale: r[17:16],
                    pmState: r[19:18], flagLoad: r[2], flag: r[3]};
      if (r[0]) begin
        mBase[r[1]]  = r[15:8];
        mScale[r[1]] = r[17:16];
        mState[r[1]] = r[19:18];
      end
      if (r[2]) begin
        mFlag = r[3];
      end
      @(posedge clock);
      sideband <= '0;
      rdNow(r[2] ? 12'h218 : 12'h214, r[2] ? {31'h0, mFlag} : expData(mSel));
      mSel = r[4] ? {7'h0, r[5]} : r[31:24];
      eNext = r[7] ? expData(mSel) : {24'h0, mSel};
      wrRd(12'h210, {r[23:20], 20'h0, mSel}, 4'h1, r[7] ? 12'h214 : 12'h210, eNext);
      wr(r[6] ? 12'h214 : 12'h218, xs(), 4'hf);
      rd(12'h214, expData(mSel));
      rd(12'h218, {31'h0, mFlag});
      rd(12'h210, {24'h0, mSel});
      rd({4'h3, r[13:6]}, 32'h0);
    end
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    modelReset();
    rd(12'h210, 32'h0);
    rd(12'h214, expData(8'h00));
    rd(12'h218, 32'h0);
    close_out();
  end

  // Normal run is about 1000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    close_out();
  end
endmodule : pbc_regs_tb
